// >>> design/sacl_menu.v
// front panel setpoint access menu and current loop configuration
`timescale 1ns/1ps
`include "sacl_defs.vh"

// ==========================================================
module sacl_menu #(
    parameter TIMEOUT_CYC = `SACL_TIMEOUT_CYC
) (
    // clock, reset, enable
    input wire pclk,
    input wire presetn,
    input wire clk_en,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // push buttons, high while pressed
    input wire btn_prog,
    input wire btn_up,
    input wire btn_down,
    input wire btn_enter,
    // surrounding instrument
    input wire cfg_mode,
    input wire cfg_code_edit,
    input wire alarm1_total,
    input wire alarm2_total,
    input wire cal_changed_rate,
    input wire cal_changed_total,
    input wire [31:0] rate_display,
    input wire [31:0] total_display,
    // display and loop outputs
    output reg [6:0] menu_state,
    output reg [31:0] edit_value,
    output reg [2:0] edit_digit,
    output reg loop_enabled,
    output reg loop_fallback,
    output reg [15:0] loop_ua
);

// ==========================================================
// states
localparam [6:0] ST_TOTALISE = 7'b0000001;
localparam [6:0] ST_CODE_PROMPT = 7'b0000010;
localparam [6:0] ST_CODE_ENTRY = 7'b0000100;
localparam [6:0] ST_SP_PROMPT = 7'b0001000;
localparam [6:0] ST_SP_EDIT = 7'b0010000;
localparam [6:0] ST_NEW_CODE = 7'b0100000;
localparam [6:0] ST_NEW_DONE = 7'b1000000;

function [26:0] bcd2bin;
    input [31:0] bcd;
    integer i;
    reg [26:0] acc;
    begin
        acc = 27'd0;
        for (i = 7; i >= 0; i = i - 1) begin
            acc = acc * 27'd10 + {23'd0, bcd[i*4 +: 4]};
        end
        bcd2bin = acc;
    end
endfunction

function [31:0] digit_mask;
    input [3:0] ndig;
    begin
        digit_mask = (ndig == 4'd8) ? 32'hFFFFFFFF :
            ((32'h00000001 << {ndig, 2'b00}) - 32'h00000001);
    end
endfunction

// ==========================================================
// registers
reg menu_en_reg;
reg loop_en_reg;
reg src_total_reg;
reg [15:0] code_active_reg;
reg [15:0] code_pending_reg;
reg [31:0] lo_reg;
reg [31:0] hi_reg;
reg [31:0] sp1_reg;
reg [31:0] sp2_reg;
reg [6:0] state_reg;
reg [31:0] edit_reg;
reg [2:0] dig_reg;
reg sel_sp2_reg;
reg [26:0] idle_cnt_reg;
reg fallback_reg;
reg [3:0] btn_q_reg;

wire prog_p = btn_prog & ~btn_q_reg[0];
wire up_p = btn_up & ~btn_q_reg[1];
wire down_p = btn_down & ~btn_q_reg[2];
wire enter_p = btn_enter & ~btn_q_reg[3];
wire any_p = prog_p | up_p | down_p | enter_p;
wire combo = btn_prog & btn_up & (prog_p | up_p);
wire sp_total = sel_sp2_reg ? alarm2_total : alarm1_total;
wire [3:0] ndig = (state_reg == ST_CODE_ENTRY ||
    state_reg == ST_NEW_CODE) ? `SACL_CODE_DIGITS :
    (sp_total ? `SACL_TOTAL_DIGITS : `SACL_RATE_DIGITS);
wire [3:0] cur_digit = edit_reg[{dig_reg, 2'b00} +: 4];
wire apb_wr = psel & penable & pready & pwrite;
wire cal_hit = src_total_reg ? cal_changed_total : cal_changed_rate;

// ==========================================================
// apb slave, one wait state per access
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h00000000;
    end else if (clk_en) begin
        if (psel && penable && !pready) begin
            pready <= 1'b1;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            if (paddr == `SACL_OFF_CTRL) begin
                prdata <= {29'd0, src_total_reg, loop_en_reg, menu_en_reg};
            end else if (paddr == `SACL_OFF_CODE) begin
                prdata <= {code_pending_reg, code_active_reg};
            end else if (paddr == `SACL_OFF_LO) begin
                prdata <= lo_reg;
            end else if (paddr == `SACL_OFF_HI) begin
                prdata <= hi_reg;
            end else if (paddr == `SACL_OFF_SP1) begin
                prdata <= sp1_reg;
            end else if (paddr == `SACL_OFF_SP2) begin
                prdata <= sp2_reg;
            end else if (paddr == `SACL_OFF_STAT) begin
                prdata <= {loop_ua, 7'd0, fallback_reg, 1'b0, state_reg};
            end else begin
                pslverr <= 1'b1;
            end
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end
end

// ==========================================================
// configuration written by software
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        menu_en_reg <= 1'b0;
        loop_en_reg <= 1'b0;
        src_total_reg <= 1'b0;
        lo_reg <= `SACL_RST_LO;
        hi_reg <= `SACL_RST_HI;
        fallback_reg <= 1'b0;
    end else if (clk_en) begin
        if (apb_wr && paddr == `SACL_OFF_CTRL) begin
            menu_en_reg <= pwdata[`SACL_CTRL_MENU_EN];
            loop_en_reg <= pwdata[`SACL_CTRL_LOOP_EN];
            src_total_reg <= pwdata[`SACL_CTRL_SRC_TOTAL];
        end
        if (apb_wr && paddr == `SACL_OFF_LO) begin
            lo_reg <= pwdata;
        end
        if (apb_wr && paddr == `SACL_OFF_HI) begin
            hi_reg <= pwdata;
        end
        // a calibration hit beats a same-cycle reconfiguration
        if (cal_hit) begin
            fallback_reg <= 1'b1;
        end else if (apb_wr && (paddr == `SACL_OFF_LO ||
                paddr == `SACL_OFF_HI || paddr == `SACL_OFF_CTRL)) begin
            fallback_reg <= 1'b0;
        end
    end
end

// ==========================================================
// push button menu
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        btn_q_reg <= 4'h0;
        state_reg <= ST_TOTALISE;
        edit_reg <= 32'h00000000;
        dig_reg <= 3'd0;
        sel_sp2_reg <= 1'b0;
        idle_cnt_reg <= 27'd0;
        code_active_reg <= `SACL_RST_CODE;
        code_pending_reg <= `SACL_RST_CODE;
        sp1_reg <= `SACL_RST_SP;
        sp2_reg <= `SACL_RST_SP;
    end else if (clk_en) begin
        btn_q_reg <= {btn_enter, btn_down, btn_up, btn_prog};
        if (any_p || state_reg == ST_TOTALISE) begin
            idle_cnt_reg <= 27'd0;
        end else begin
            idle_cnt_reg <= idle_cnt_reg + 27'd1;
        end
        if (apb_wr && paddr == `SACL_OFF_CODE) begin
            code_pending_reg <= pwdata[15:0];
        end
        if (apb_wr && paddr == `SACL_OFF_SP1) begin
            sp1_reg <= pwdata & digit_mask(alarm1_total ?
                `SACL_TOTAL_DIGITS : `SACL_RATE_DIGITS);
        end
        if (apb_wr && paddr == `SACL_OFF_SP2) begin
            sp2_reg <= pwdata & digit_mask(alarm2_total ?
                `SACL_TOTAL_DIGITS : `SACL_RATE_DIGITS);
        end
        // digit editing shared by every entry state
        if (state_reg == ST_CODE_ENTRY || state_reg == ST_SP_EDIT ||
                state_reg == ST_NEW_CODE) begin
            if (up_p) begin
                edit_reg[{dig_reg, 2'b00} +: 4] <=
                    (cur_digit == 4'h9) ? 4'h0 : cur_digit + 4'h1;
            end else if (down_p) begin
                edit_reg[{dig_reg, 2'b00} +: 4] <=
                    (cur_digit == 4'h0) ? 4'h9 : cur_digit - 4'h1;
            end else if (prog_p) begin
                dig_reg <= ({1'b0, dig_reg} == ndig - 4'd1) ?
                    3'd0 : dig_reg + 3'd1;
            end
        end
        if (idle_cnt_reg >= TIMEOUT_CYC - 1 &&
                state_reg != ST_NEW_CODE && state_reg != ST_NEW_DONE) begin
            state_reg <= ST_TOTALISE;
        end else begin
            case (state_reg)
            ST_TOTALISE: begin
                if (!cfg_mode) begin
                    code_active_reg <= code_pending_reg;
                end
                if (cfg_mode && cfg_code_edit) begin
                    edit_reg <= 32'h00000000;
                    dig_reg <= 3'd0;
                    state_reg <= ST_NEW_CODE;
                end else if (!cfg_mode && menu_en_reg && combo) begin
                    sel_sp2_reg <= 1'b0;
                    if (code_active_reg == 16'h0000) begin
                        state_reg <= ST_SP_PROMPT;
                    end else begin
                        state_reg <= ST_CODE_PROMPT;
                    end
                end
            end
            ST_CODE_PROMPT: begin
                if (prog_p) begin
                    edit_reg <= 32'h00000000;
                    dig_reg <= 3'd0;
                    state_reg <= ST_CODE_ENTRY;
                end
            end
            ST_CODE_ENTRY: begin
                if (enter_p) begin
                    if (edit_reg[15:0] == code_active_reg) begin
                        sel_sp2_reg <= 1'b0;
                        state_reg <= ST_SP_PROMPT;
                    end else begin
                        state_reg <= ST_TOTALISE;
                    end
                end
            end
            ST_SP_PROMPT: begin
                if (up_p || down_p) begin
                    sel_sp2_reg <= ~sel_sp2_reg;
                end else if (prog_p) begin
                    edit_reg <= sel_sp2_reg ? sp2_reg : sp1_reg;
                    dig_reg <= 3'd0;
                    state_reg <= ST_SP_EDIT;
                end else if (enter_p) begin
                    state_reg <= ST_TOTALISE;
                end
            end
            ST_SP_EDIT: begin
                if (enter_p) begin
                    if (sel_sp2_reg) begin
                        sp2_reg <= edit_reg & digit_mask(ndig);
                    end else begin
                        sp1_reg <= edit_reg & digit_mask(ndig);
                    end
                    state_reg <= ST_SP_PROMPT;
                end
            end
            ST_NEW_CODE: begin
                if (enter_p) begin
                    state_reg <= ST_NEW_DONE;
                end
            end
            ST_NEW_DONE: begin
                if (enter_p) begin
                    code_pending_reg <= edit_reg[15:0];
                    state_reg <= ST_TOTALISE;
                end
            end
            default: begin
                state_reg <= ST_TOTALISE;
            end
            endcase
        end
    end
end

// ==========================================================
// current loop: serial divider, one result every 42 cycles
reg [40:0] rem_reg;
reg [40:0] quo_reg;
reg [26:0] den_reg;
reg [5:0] div_cnt_reg;
reg [15:0] ua_calc_reg;

wire [26:0] x_bin = bcd2bin(src_total_reg ? total_display : rate_display);
wire [26:0] lo_bin = bcd2bin(lo_reg);
wire [26:0] hi_bin = bcd2bin(hi_reg);
wire [27:0] rem_shift = {rem_reg[26:0], quo_reg[40]};
wire rem_ge = rem_shift >= {1'b0, den_reg};

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        rem_reg <= 41'd0;
        quo_reg <= 41'd0;
        den_reg <= 27'd0;
        div_cnt_reg <= 6'd0;
        ua_calc_reg <= `SACL_UA_LOW;
    end else if (clk_en) begin
        if (div_cnt_reg == 6'd0) begin
            if (hi_bin <= lo_bin || x_bin <= lo_bin) begin
                ua_calc_reg <= `SACL_UA_LOW;
            end else if (x_bin >= hi_bin) begin
                ua_calc_reg <= `SACL_UA_HIGH;
            end else begin
                quo_reg <= {14'd0, x_bin - lo_bin} * 41'd16000;
                rem_reg <= 41'd0;
                den_reg <= hi_bin - lo_bin;
                div_cnt_reg <= 6'd41;
            end
        end else begin
            rem_reg <= {13'd0, rem_ge ? rem_shift - {1'b0, den_reg} :
                rem_shift};
            quo_reg <= {quo_reg[39:0], rem_ge};
            div_cnt_reg <= div_cnt_reg - 6'd1;
            if (div_cnt_reg == 6'd1) begin
                ua_calc_reg <= `SACL_UA_LOW +
                    {quo_reg[14:0], rem_ge};
            end
        end
    end
end

// ==========================================================
// registered outputs
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        menu_state <= ST_TOTALISE;
        edit_value <= 32'h00000000;
        edit_digit <= 3'd0;
        loop_enabled <= 1'b0;
        loop_fallback <= 1'b0;
        loop_ua <= 16'd0;
    end else if (clk_en) begin
        menu_state <= state_reg;
        edit_value <= (state_reg == ST_SP_PROMPT) ? {31'd0, sel_sp2_reg} :
            edit_reg;
        edit_digit <= dig_reg;
        loop_enabled <= loop_en_reg;
        loop_fallback <= fallback_reg;
        // disabled loop drives no current; a calibration change of the selected source forces the fallback current
        if (!loop_en_reg) begin
            loop_ua <= 16'd0;
        end else if (fallback_reg) begin
            loop_ua <= `SACL_UA_FALLBACK;
        end else begin
            loop_ua <= ua_calc_reg;
        end
    end
end

endmodule // sacl_menu

// >>> design/sacl_defs.vh
// constants for the setpoint access and current loop menu block
`ifndef SACL_DEFS_VH
`define SACL_DEFS_VH

// ==========================================================
// register byte offsets
`define SACL_OFF_CTRL 8'h00
`define SACL_OFF_CODE 8'h04
`define SACL_OFF_LO 8'h08
`define SACL_OFF_HI 8'h0C
`define SACL_OFF_SP1 8'h10
`define SACL_OFF_SP2 8'h14
`define SACL_OFF_STAT 8'h18

// ==========================================================
// control field positions
`define SACL_CTRL_MENU_EN 0
`define SACL_CTRL_LOOP_EN 1
`define SACL_CTRL_SRC_TOTAL 2

// ==========================================================
// reset values
`define SACL_RST_CODE 16'h0000
`define SACL_RST_LO 32'h00000000
`define SACL_RST_HI 32'h00999999
`define SACL_RST_SP 32'h00000000

// ==========================================================
// digit counts and loop currents in microamps
`define SACL_CODE_DIGITS 4'd4
`define SACL_RATE_DIGITS 4'd6
`define SACL_TOTAL_DIGITS 4'd8
`define SACL_UA_LOW 16'd4000
`define SACL_UA_HIGH 16'd20000
`define SACL_UA_SPAN 16'd16000
`define SACL_UA_FALLBACK 16'd3500

// ==========================================================
// timing
`define SACL_CLK_HZ 10000000
`define SACL_TIMEOUT_S 10
`define SACL_TIMEOUT_CYC (`SACL_TIMEOUT_S * `SACL_CLK_HZ)

`endif

// >>> dv/sacl_menu_chk.sv
// assertion checker bound to the setpoint menu block
`timescale 1ns/1ps
// ==========================================================
// port watcher
module sacl_menu_chk #(
    parameter TIMEOUT_CYC = 200
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb
    input wire psel,
    input wire penable,
    input wire pready,
    input wire pslverr,
    // buttons and menu
    input wire btn_prog,
    input wire btn_up,
    input wire btn_down,
    input wire btn_enter,
    input wire cfg_code_edit,
    input wire [6:0] menu_state,
    input wire [31:0] edit_value,
    // loop
    input wire loop_enabled,
    input wire loop_fallback,
    input wire [15:0] loop_ua
);
    reg [31:0] idle_reg;
    wire any_btn = btn_prog | btn_up | btn_down | btn_enter;
    // slack of 6 covers the two-edge answer plus the display lag
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            idle_reg <= 32'h0;
        else if (!(|menu_state[4:1]) || any_btn)
            idle_reg <= 32'h0;
        else
            idle_reg <= idle_reg + 32'h1;
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_ready_pulse; pready |=> !pready; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready held");
    property p_ready_cause; pready |-> $past(psel && penable); endproperty
    a_ready_cause: assert property (p_ready_cause) else $error("stray pready");
    property p_err_ready; pslverr |-> pready; endproperty
    a_err_ready: assert property (p_err_ready) else $error("lone pslverr");
    property p_onehot; $onehot(menu_state); endproperty
    a_onehot: assert property (p_onehot) else $error("state not one-hot");
    property p_exit_cause;
        $fell(menu_state[0]) |-> $past(btn_up, 2) || $past(btn_up, 3) ||
            $past(cfg_code_edit, 2) || $past(cfg_code_edit, 3);
    endproperty
    a_exit_cause: assert property (p_exit_cause) else $error("bad entry");
    property p_entry;
        $fell(menu_state[0]) |-> menu_state inside {7'h02, 7'h08, 7'h20};
    endproperty
    a_entry: assert property (p_entry) else $error("bad entry state");
    property p_new_zero; $rose(menu_state[5]) |-> edit_value == 32'h0;
    endproperty
    a_new_zero: assert property (p_new_zero) else $error("code not 0");
    property p_timeout; idle_reg <= TIMEOUT_CYC + 6; endproperty
    a_timeout: assert property (p_timeout) else $error("no timeout");
    property p_loop_off; (!loop_enabled) [*2] |-> loop_ua == 16'h0000;
    endproperty
    a_loop_off: assert property (p_loop_off) else $error("off not 0");
    property p_fallback;
        (loop_enabled && loop_fallback) [*2] |-> loop_ua == 16'h0DAC;
    endproperty
    a_fallback: assert property (p_fallback) else $error("no 3.5mA");
    property p_range;
        loop_enabled && !loop_fallback && loop_ua != 16'h0000 |->
            loop_ua >= 16'h0FA0 && loop_ua <= 16'h4E20;
    endproperty
    a_range: assert property (p_range) else $error("loop out of span");
    c_edit: cover property (menu_state == 7'h10);
    c_code: cover property (menu_state == 7'h04);
    c_fallback: cover property (loop_enabled && loop_fallback);
endmodule // sacl_menu_chk

bind sacl_menu sacl_menu_chk #(.TIMEOUT_CYC(TIMEOUT_CYC)) i_sacl_menu_chk (
    .pclk, .presetn, .psel, .penable, .pready, .pslverr, .btn_prog,
    .btn_up, .btn_down, .btn_enter, .cfg_code_edit, .menu_state,
    .edit_value, .loop_enabled, .loop_fallback, .loop_ua);

// >>> dv/sacl_btn_model.sv
// push button operator model for the setpoint menu bench
`timescale 1ns/1ps
// ==========================================================
// operator at the front panel
module sacl_btn_model (
    // clock
    input wire pclk,
    // buttons, high while pressed
    output reg btn_prog,
    output reg btn_up,
    output reg btn_down,
    output reg btn_enter
);
    int hold = 2;
    initial {btn_prog, btn_up, btn_down, btn_enter} = 4'h0;
    // hold sets a brisk or a slow operator; all keys in m rise together
    task press(input logic [3:0] m);
        @(posedge pclk);
        {btn_prog, btn_up, btn_down, btn_enter} <= m;
        repeat (hold) @(posedge pclk);
        {btn_prog, btn_up, btn_down, btn_enter} <= 4'h0;
        repeat (4) @(posedge pclk);
    endtask
endmodule // sacl_btn_model

// >>> dv/tb_top.sv
// self-checking bench for the setpoint menu block
`timescale 1ns/1ps
`include "sacl_defs.vh"
// ==========================================================
// bench top
module tb_top;
    localparam int TMO = 200;
    localparam logic [3:0] P = 4'h8, U = 4'h4, D = 4'h2, E = 4'h1;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, cfg_mode = 1'b0, cfg_code_edit = 1'b0, clk_en = 1'b1;
    logic cal_rate = 1'b0, cal_total = 1'b0, er;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rate_d = 32'h0, total_d = 32'h0, rd;
    wire [31:0] prdata, edit_value;
    wire pready, pslverr, btn_prog, btn_up, btn_down, btn_enter;
    wire [6:0] menu_state;
    wire [2:0] edit_digit;
    wire loop_enabled, loop_fallback;
    wire [15:0] loop_ua;
    int err_count = 0, checks = 0;
    // write, address, data, expected read, expected error
    logic [73:0] rows [0:11] = '{
        {1'b0, `SACL_OFF_HI, 32'h0, 32'h00999999, 1'b0},
        {1'b0, `SACL_OFF_LO, 32'h0, 32'h0, 1'b0},
        {1'b0, `SACL_OFF_CODE, 32'h0, 32'h0, 1'b0},
        {1'b1, `SACL_OFF_SP1, 32'h12345678, 32'h0, 1'b0},
        {1'b0, `SACL_OFF_SP1, 32'h0, 32'h00345678, 1'b0},
        {1'b1, `SACL_OFF_SP2, 32'h12345678, 32'h0, 1'b0},
        {1'b0, `SACL_OFF_SP2, 32'h0, 32'h12345678, 1'b0},
        {1'b1, 8'h1C, 32'hFFFFFFFF, 32'h0, 1'b1},
        {1'b0, 8'h1C, 32'h0, 32'h0, 1'b1},
        {1'b1, `SACL_OFF_STAT, 32'hFFFFFFFF, 32'h0, 1'b0},
        {1'b0, `SACL_OFF_STAT, 32'h0, 32'h00000001, 1'b0},
        {1'b0, `SACL_OFF_CTRL, 32'h0, 32'h0, 1'b0}};

    always #50 pclk = ~pclk;

    sacl_menu #(.TIMEOUT_CYC(TMO)) i_sacl_menu (
        .pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .btn_prog, .btn_up, .btn_down,
        .btn_enter, .cfg_mode, .cfg_code_edit, .alarm1_total(1'b0),
        .alarm2_total(1'b1), .cal_changed_rate(cal_rate),
        .cal_changed_total(cal_total), .rate_display(rate_d),
        .total_display(total_d), .menu_state, .edit_value, .edit_digit,
        .loop_enabled, .loop_fallback, .loop_ua);
    sacl_btn_model i_sacl_btn_model (
        .pclk, .btn_prog, .btn_up, .btn_down, .btn_enter);

    task give_verdict;
        $display("checks=%0d mismatches=%0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task wt(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            err_count++;
            give_verdict();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task pr(input logic [3:0] m, input logic [6:0] st);
        i_sacl_btn_model.press(m);
        chk(32'(menu_state), 32'(st));
    endtask

    initial begin
        wt(2);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            apb(rows[i][73], rows[i][72:65], rows[i][64:33]);
            if (!rows[i][73])
                chk(rd, rows[i][32:1]);
            chk(32'(er), 32'(rows[i][0]));
        end
        $display("register rows done");
        // ==========================================================
        // current loop output
        apb(1'b1, `SACL_OFF_HI, 32'h00001000);
        rate_d <= 32'h00000500;
        apb(1'b1, `SACL_OFF_CTRL, 32'h3);
        wt(60);
        chk(32'(loop_ua), 32'h2EE0);
        chk(32'(loop_enabled), 32'h1);
        cal_total <= 1'b1;
        wt(1);
        cal_total <= 1'b0;
        wt(3);
        chk(32'(loop_fallback), 32'h0);
        cal_rate <= 1'b1;
        wt(1);
        cal_rate <= 1'b0;
        wt(3);
        chk(32'(loop_ua), 32'h0DAC);
        apb(1'b1, `SACL_OFF_CTRL, 32'h1);
        wt(3);
        chk(32'(loop_ua), 32'h0);
        chk(32'(loop_fallback), 32'h0);
        apb(1'b0, `SACL_OFF_HI, 32'h0);
        chk(rd, 32'h00001000);
        total_d <= 32'h00002000;
        apb(1'b1, `SACL_OFF_CTRL, 32'h7);
        wt(60);
        chk(32'(loop_ua), 32'h4E20);
        apb(1'b1, `SACL_OFF_CTRL, 32'h1);
        $display("loop output done");
        // ==========================================================
        // unprotected setpoint edit, then menu disabled
        pr(P | U, 7'h08);
        pr(U, 7'h08);
        chk(32'(edit_value[0]), 32'h1);
        pr(D, 7'h08);
        chk(32'(edit_value[0]), 32'h0);
        pr(P, 7'h10);
        chk(edit_value, 32'h00345678);
        pr(U, 7'h10);
        chk(edit_value, 32'h00345679);
        pr(E, 7'h08);
        pr(E, 7'h01);
        apb(1'b0, `SACL_OFF_SP1, 32'h0);
        chk(rd, 32'h00345679);
        apb(1'b1, `SACL_OFF_CTRL, 32'h0);
        pr(P | U, 7'h01);
        apb(1'b1, `SACL_OFF_CTRL, 32'h1);
        $display("setpoint edit done");
        // ==========================================================
        // new access code, slow operator on the first digit
        cfg_mode <= 1'b1;
        cfg_code_edit <= 1'b1;
        wt(1);
        cfg_code_edit <= 1'b0;
        wt(3);
        chk(32'(menu_state), 32'h20);
        i_sacl_btn_model.hold = 6;
        pr(U, 7'h20);
        i_sacl_btn_model.hold = 2;
        pr(P, 7'h20);
        chk(32'(edit_digit), 32'h1);
        pr(U, 7'h20);
        pr(U, 7'h20);
        chk(edit_value, 32'h00000021);
        pr(E, 7'h40);
        pr(E, 7'h01);
        apb(1'b0, `SACL_OFF_CODE, 32'h0);
        chk(rd, 32'h00210000);
        cfg_mode <= 1'b0;
        wt(3);
        apb(1'b0, `SACL_OFF_CODE, 32'h0);
        chk(rd, 32'h00210021);
        $display("new code done");
        // ==========================================================
        // protected access: timeout, wrong code, right code
        // frozen clock enable must swallow the combination
        clk_en <= 1'b0;
        pr(P | U, 7'h01);
        clk_en <= 1'b1;
        pr(P | U, 7'h02);
        wt(TMO + 10);
        chk(32'(menu_state), 32'h01);
        pr(P | U, 7'h02);
        pr(P, 7'h04);
        pr(E, 7'h01);
        pr(P | U, 7'h02);
        pr(P, 7'h04);
        pr(U, 7'h04);
        pr(P, 7'h04);
        pr(U, 7'h04);
        pr(U, 7'h04);
        pr(E, 7'h08);
        pr(P, 7'h10);
        pr(D, 7'h10);
        chk(edit_value, 32'h00345678);
        $display("protected access done");
        // ==========================================================
        // reset in mid-edit clears state, loop current and menu enable
        presetn <= 1'b0;
        wt(2);
        presetn <= 1'b1;
        chk(32'(menu_state), 32'h01);
        chk(32'(loop_ua), 32'h0);
        pr(P | U, 7'h01);
        $display("reset test done");
        give_verdict();
    end
endmodule // tb_top
